/* File: rtl/tcc_port.sv */
// Purpose: Character-serial channel port to a magnetic tape unit
// Assumes: Tape pins asynchronous; registers over AXI4-Lite
// Notes:   Four six-bit characters make one 24-bit word
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module tcc_port (
   // System
   input  wire logic                       clock_in,
   input  wire logic                       sys_rst_in,
   // AXI4-Lite write
   input  wire logic [tcc_pkg::AXI_AW-1:0] s_axi_awaddr_in,
   input  wire logic                       s_axi_awvalid_in,
   output logic                            s_axi_awready_out,
   input  wire logic [31:0]                s_axi_wdata_in,
   input  wire logic [3:0]                 s_axi_wstrb_in,
   input  wire logic                       s_axi_wvalid_in,
   output logic                            s_axi_wready_out,
   output logic [1:0]                      s_axi_bresp_out,
   output logic                            s_axi_bvalid_out,
   input  wire logic                       s_axi_bready_in,
   // AXI4-Lite read
   input  wire logic [tcc_pkg::AXI_AW-1:0] s_axi_araddr_in,
   input  wire logic                       s_axi_arvalid_in,
   output logic                            s_axi_arready_out,
   output logic [31:0]                     s_axi_rdata_out,
   output logic [1:0]                      s_axi_rresp_out,
   output logic                            s_axi_rvalid_out,
   input  wire logic                       s_axi_rready_in,
   // Tape unit inputs, index 0 is the sixth line
   input  wire logic [tcc_pkg::CHAR_W-1:0] char_in_n_in,
   input  wire logic                       char_par_n_in,
   input  wire logic                       xfer_strobe_in,
   input  wire logic                       halt_n_in,
   input  wire logic                       skip_resp_n_in,
   input  wire logic                       gap_n_in,
   input  wire logic                       error_n_in,
   // Tape unit outputs, index 0 is the sixth line
   output logic [tcc_pkg::CHAR_W-1:0]      char_out,
   output logic                            char_par_out,
   output logic                            buf_ctl_strobe_out,
   output logic                            io_ctl_strobe_out,
   output logic                            halt_interlock_out,
   output logic                            xfer_pending_out,
   output logic                            clock_present_out,
   output logic                            phase_window_t6_t3_out,
   output logic                            direction_bit_out,
   output logic [tcc_pkg::ADDR_W-1:0]      unit_addr_out
);
   import tcc_pkg::*;

   function automatic logic odd_ones(input logic [CHAR_W:0] v);
      return ^v;
   endfunction

   // Synchronised pins
   logic [CHAR_W-1:0] char_n_s;
   logic              par_n_s;
   logic              strobe_s;
   logic              halt_n_s;
   logic              skip_n_s;
   logic              gap_n_s;
   logic              err_n_s;
   logic              strobe_prev_ff;
   logic [2:0]        phase;
   logic              ph_tick;

   tcc_sync #(.W(CHAR_W + 1), .RST_V(32'h7F)) u_sync_char (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .d_in       ({char_par_n_in, char_in_n_in}),
      .q_out      ({par_n_s, char_n_s})
   );
   tcc_sync #(.W(5), .RST_V(32'h1F)) u_sync_ctl (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .d_in       ({xfer_strobe_in, halt_n_in, skip_resp_n_in, gap_n_in, error_n_in}),
      .q_out      ({strobe_s, halt_n_s, skip_n_s, gap_n_s, err_n_s})
   );
   tcc_phase u_phase (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .phase_out  (phase),
      .tick_out   (ph_tick)
   );

   // Registers
   tcc_state_t        state_ff;
   logic [WORD_W-1:0] word_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic              wrdy_ff;
   logic              perr_ff;
   logic              err_ff;
   logic              gap_ff;
   logic              halted_ff;
   logic              skip_ff;
   logic              aw_ff;
   logic              w_ff;
   logic [AXI_AW-1:0] awaddr_ff;
   logic [31:0]       wdata_ff;

   // Write decode
   wire do_wr    = aw_ff && w_ff && !s_axi_bvalid_out;
   wire wr_ctrl  = do_wr && awaddr_ff == OFS_CTRL;
   wire wr_stat  = do_wr && awaddr_ff == OFS_STAT;
   wire wr_data  = do_wr && awaddr_ff == OFS_DATA;
   wire wr_instr = do_wr && awaddr_ff == OFS_INSTR;
   wire wr_map   = wr_ctrl || wr_stat || wr_data || wr_instr;
   wire start    = wr_ctrl && wdata_ff[CTL_EN];
   wire rd_go    = s_axi_arvalid_in && s_axi_arready_out;
   wire rd_data  = rd_go && s_axi_araddr_in == OFS_DATA;

   // Channel events
   wire strobe_rise = strobe_s && !strobe_prev_ff;
   wire halt_req    = !halt_n_s && state_ff != CH_IDLE;
   wire ph_t0       = ph_tick && phase == PH_T0;
   wire in_on       = state_ff == CH_IN;
   wire out_on      = state_ff == CH_OUT;
   wire ev_capture  = in_on && strobe_rise && !xfer_pending_out;
   wire ev_move_in  = in_on && ph_t0 && xfer_pending_out;
   wire ev_load_out = out_on && ph_t0 && xfer_pending_out && !clock_present_out;
   wire ev_taken    = out_on && strobe_rise && !clock_present_out && !xfer_pending_out;
   wire ev_done_out = out_on && ph_t0 && clock_present_out;
   wire last_char   = cnt_ff == CNT_W'(WORD_CHARS);
   wire word_full   = cnt_ff == CNT_W'(WORD_CHARS - 1);

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         strobe_prev_ff <= 1'b1;                                    // Strobe idles high
      else
         strobe_prev_ff <= strobe_s;
   end

   // Channel state
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         state_ff <= CH_IDLE;
      else if (halt_req)
         state_ff <= CH_IDLE;
      else if (wr_ctrl)
      begin
         case ({wdata_ff[CTL_EN], wdata_ff[CTL_DIR]})
            2'b10:   state_ff <= CH_IN;
            2'b11:   state_ff <= CH_OUT;
            default: state_ff <= CH_IDLE;
         endcase
      end
   end

   // Direction and unit address
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         direction_bit_out <= 1'b0;
         unit_addr_out     <= '0;
      end
      else if (wr_ctrl)
      begin
         direction_bit_out <= wdata_ff[CTL_DIR];
         unit_addr_out     <= wdata_ff[CTL_UA_LSB +: ADDR_W];
      end
   end

   // Character register and its parity
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         char_out     <= '0;
         char_par_out <= 1'b1;
      end
      else if (ev_capture)
      begin
         char_out     <= ~char_n_s;
         char_par_out <= ~par_n_s;
      end
      else if (ev_load_out)
      begin
         char_out     <= word_ff[WORD_W-1 -: CHAR_W];
         char_par_out <= ~odd_ones({1'b0, word_ff[WORD_W-1 -: CHAR_W]});
      end
   end

   // Word register; newest input character lands in the low bits
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         word_ff <= '0;
      else if (wr_data && out_on)
         word_ff <= wdata_ff[WORD_W-1:0];
      else if (ev_move_in)
         word_ff <= {word_ff[WORD_W-CHAR_W-1:0], char_out};
      else if (ev_load_out)
         word_ff <= {word_ff[WORD_W-CHAR_W-1:0], {CHAR_W{1'b0}}};
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         cnt_ff <= '0;
      else if (start || (wr_data && out_on) || (ev_move_in && word_full))
         cnt_ff <= '0;
      else if (ev_move_in || ev_load_out)
         cnt_ff <= cnt_ff + CNT_W'(1);
   end

   // Word ready: input word complete or output word drained
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         wrdy_ff <= 1'b0;
      else if ((ev_move_in && word_full) || (ev_done_out && last_char))
         wrdy_ff <= 1'b1;
      else if (start || rd_data || wr_data)
         wrdy_ff <= 1'b0;
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         xfer_pending_out <= 1'b0;
      else if (halt_req || start)
         xfer_pending_out <= 1'b0;
      else if (ev_capture || (wr_data && out_on) || (ev_done_out && !last_char))
         xfer_pending_out <= 1'b1;
      else if (ev_move_in || ev_load_out)
         xfer_pending_out <= 1'b0;
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         clock_present_out <= 1'b0;
      else if (halt_req || start)
         clock_present_out <= 1'b0;
      else if (ev_capture || ev_taken)
         clock_present_out <= 1'b1;
      else if (ev_move_in || ev_done_out)
         clock_present_out <= 1'b0;
   end

   // Input: set at first processed character; output: at last one
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         halt_interlock_out <= 1'b0;
      else if (start)
         halt_interlock_out <= 1'b0;
      else if (ev_move_in || (ev_done_out && last_char))
         halt_interlock_out <= 1'b1;
   end

   // Registered, so the window trails the phase by one clock
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         phase_window_t6_t3_out <= 1'b0;
      else
         phase_window_t6_t3_out <= phase >= PH_T6 || phase <= PH_T3;
   end

   // Instruction strobes, one clock each
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         buf_ctl_strobe_out <= 1'b0;
         io_ctl_strobe_out  <= 1'b0;
      end
      else
      begin
         buf_ctl_strobe_out <= wr_instr && wdata_ff[INS_EOM] && !wdata_ff[INS_IOMODE];
         io_ctl_strobe_out  <= wr_instr && wdata_ff[INS_EOM] && wdata_ff[INS_IOMODE];
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   wire clr_go = wr_stat;
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         perr_ff   <= 1'b0;
         err_ff    <= 1'b0;
         gap_ff    <= 1'b0;
         halted_ff <= 1'b0;
      end
      else
      begin
         perr_ff   <= (ev_capture && !odd_ones({~par_n_s, ~char_n_s}))
                      || (perr_ff && !(clr_go && wdata_ff[ST_PERR]));
         err_ff    <= !err_n_s || (err_ff && !(clr_go && wdata_ff[ST_ERR]));
         gap_ff    <= !gap_n_s || (gap_ff && !(clr_go && wdata_ff[ST_GAP]));
         halted_ff <= halt_req || (halted_ff && !(clr_go && wdata_ff[ST_HALTED]));
      end
   end

   // Skip test samples the response line at the instruction
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         skip_ff <= 1'b0;
      else if (wr_instr && wdata_ff[INS_SKS])
         skip_ff <= !skip_n_s;
   end

   // AXI write: address and data taken in either order
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         aw_ff     <= 1'b0;
         awaddr_ff <= '0;
      end
      else if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         aw_ff     <= 1'b1;
         awaddr_ff <= s_axi_awaddr_in;
      end
      else if (do_wr)
         aw_ff <= 1'b0;
   end

   // Byte strobes ignored: every field sits in the low bytes
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         w_ff     <= 1'b0;
         wdata_ff <= '0;
      end
      else if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         w_ff     <= 1'b1;
         wdata_ff <= s_axi_wdata_in;
      end
      else if (do_wr)
         w_ff <= 1'b0;
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready_out <= !aw_ff && !(s_axi_awvalid_in && s_axi_awready_out)
                              && !s_axi_bvalid_out;
         s_axi_wready_out  <= !w_ff && !(s_axi_wvalid_in && s_axi_wready_out)
                              && !s_axi_bvalid_out;
         if (do_wr)
         begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
      end
   end

   // AXI read
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      case (s_axi_araddr_in)
         OFS_CTRL:
         begin
            rd_mux[CTL_EN]                   = state_ff != CH_IDLE;
            rd_mux[CTL_DIR]                  = direction_bit_out;
            rd_mux[CTL_UA_LSB +: ADDR_W]     = unit_addr_out;
         end
         OFS_STAT:
         begin
            rd_mux[ST_ACTIVE] = state_ff != CH_IDLE;
            rd_mux[ST_PEND]   = xfer_pending_out;
            rd_mux[ST_CLKP]   = clock_present_out;
            rd_mux[ST_HALTIL] = halt_interlock_out;
            rd_mux[ST_WRDY]   = wrdy_ff;
            rd_mux[ST_PERR]   = perr_ff;
            rd_mux[ST_ERR]    = err_ff;
            rd_mux[ST_GAP]    = gap_ff;
            rd_mux[ST_HALTED] = halted_ff;
            rd_mux[ST_SKIP]   = skip_ff;
         end
         OFS_DATA: rd_mux[WORD_W-1:0] = word_ff;
         default:  rd_mux = '0;
      endcase
   end

   wire rd_map = s_axi_araddr_in == OFS_CTRL || s_axi_araddr_in == OFS_STAT
                 || s_axi_araddr_in == OFS_DATA;

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= '0;
         s_axi_rresp_out   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready_out <= !s_axi_rvalid_out && !rd_go;
         if (rd_go)
         begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_mux;
            s_axi_rresp_out  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
      end
   end
endmodule // tcc_port

/* File: rtl/tcc_pkg.sv */
// Purpose: Shared constants for the tape character channel port
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package tcc_pkg;
   localparam int          CHAR_W     = 6;
   localparam int          ADDR_W     = 5;
   localparam int          WORD_CHARS = 4;
   localparam int          WORD_W     = CHAR_W * WORD_CHARS;
   localparam int          CNT_W      = 3;
   localparam int          PHASE_W    = 3;
   // Timing of one computer cycle phase
   localparam int          CLK_NS     = 10;
   localparam int          PHASE_NS   = 20;
   localparam int          PHASE_CLKS = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0]  PH_T0      = 3'h0;
   localparam logic [2:0]  PH_T3      = 3'h3;
   localparam logic [2:0]  PH_T6      = 3'h6;
   // Register map
   localparam int          AXI_AW     = 8;
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_STAT   = 8'h04;
   localparam logic [7:0]  OFS_DATA   = 8'h08;
   localparam logic [7:0]  OFS_INSTR  = 8'h0C;
   // Control fields
   localparam int          CTL_EN     = 0;
   localparam int          CTL_DIR    = 1;
   localparam int          CTL_UA_LSB = 2;
   // Instruction fields
   localparam int          INS_EOM    = 0;
   localparam int          INS_IOMODE = 1;
   localparam int          INS_SKS    = 2;
   // Status fields
   localparam int          ST_ACTIVE  = 0;
   localparam int          ST_PEND    = 1;
   localparam int          ST_CLKP    = 2;
   localparam int          ST_HALTIL  = 3;
   localparam int          ST_WRDY    = 4;
   localparam int          ST_PERR    = 5;
   localparam int          ST_ERR     = 6;
   localparam int          ST_GAP     = 7;
   localparam int          ST_HALTED  = 8;
   localparam int          ST_SKIP    = 9;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_IN   = 2'b01,
      CH_OUT  = 2'b10
   } tcc_state_t;
endpackage

/* File: rtl/tcc_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clock_in
// Notes:   Only stage two is visible outside
`timescale 1ns/10ps
module tcc_sync #(
   parameter int          W     = 1,
   parameter logic [31:0] RST_V = 32'h0
) (
   // System
   input  wire logic         clock_in,
   input  wire logic         sys_rst_in,
   // Data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         meta_ff <= RST_V[W-1:0];
         q_out   <= RST_V[W-1:0];
      end
      else
      begin
         meta_ff <= d_in;
         q_out   <= meta_ff;
      end
   end
endmodule // tcc_sync

/* File: rtl/tcc_phase.sv */
// Purpose: Computer cycle phase generator T0 to T7
// Assumes: PHASE_CLKS system clocks per phase
// Notes:   tick_out pulses on the first clock of each phase
`timescale 1ns/10ps
module tcc_phase (
   // System
   input  wire logic         clock_in,
   input  wire logic         sys_rst_in,
   // Phase
   output logic [2:0]        phase_out,
   output logic              tick_out
);
   import tcc_pkg::*;
   logic [3:0] div_ff;
   wire        wrap = (div_ff == 4'(PHASE_CLKS - 1));
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         div_ff <= 4'h0;
      else
         div_ff <= wrap ? 4'h0 : div_ff + 4'h1;
   end
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         phase_out <= PH_T0;
         tick_out  <= 1'b0;
      end
      else
      begin
         tick_out <= wrap;
         if (wrap)
            phase_out <= phase_out + 3'h1;
      end
   end
endmodule // tcc_phase

/* File: bench/tcc_port_sva.sv */
// Purpose: Port-level checks for the tape character channel port
// Assumes: Only top-level ports are visible
// Notes:   Bound into the port after endmodule
`timescale 1ns/10ps
module tcc_port_sva (
   // System
   input wire logic                       clock_in,
   input wire logic                       sys_rst_in,
   // Watched outputs
   input wire logic                       s_axi_bvalid_out,
   input wire logic [tcc_pkg::CHAR_W-1:0] char_out,
   input wire logic                       char_par_out,
   input wire logic                       buf_ctl_strobe_out,
   input wire logic                       io_ctl_strobe_out,
   input wire logic                       xfer_pending_out,
   input wire logic                       clock_present_out,
   input wire logic                       phase_window_t6_t3_out,
   input wire logic                       direction_bit_out,
   input wire logic [tcc_pkg::ADDR_W-1:0] unit_addr_out,
   // Watched inputs
   input wire logic                       halt_n_in
);
   import tcc_pkg::*;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   // T4 and T5 are two phases of two clocks each
   sequence s_win_low;
      !phase_window_t6_t3_out [*4] ##1 phase_window_t6_t3_out;
   endsequence
   sequence s_cleared;
      !xfer_pending_out && !clock_present_out;
   endsequence
   a_win_low_span: assert property ($fell(phase_window_t6_t3_out) |-> s_win_low)
      else $error("window low span wrong");
   a_win_high_span: assert property ($rose(phase_window_t6_t3_out) |-> phase_window_t6_t3_out [*8])
      else $error("window high span short");
   a_buc_one_clock: assert property (buf_ctl_strobe_out |=> !buf_ctl_strobe_out)
      else $error("buffer strobe too long");
   a_ioc_one_clock: assert property (io_ctl_strobe_out |=> !io_ctl_strobe_out)
      else $error("io strobe too long");
   a_out_par_odd: assert property (direction_bit_out |-> ^{char_out, char_par_out})
      else $error("output parity not odd");
   a_clkp_sets_pend: assert property ($rose(clock_present_out) && !direction_bit_out |-> xfer_pending_out)
      else $error("capture without pending");
   a_clkp_drop_pend: assert property ($fell(clock_present_out) && !direction_bit_out |-> !xfer_pending_out)
      else $error("pending left after move");
   a_halt_clears: assert property ($fell(halt_n_in) |-> ##5 s_cleared)
      else $error("halt did not clear flags");
   a_ua_by_write: assert property ($changed(unit_addr_out) |-> $rose(s_axi_bvalid_out))
      else $error("unit address changed alone");
   a_dir_by_write: assert property ($changed(direction_bit_out) |-> $rose(s_axi_bvalid_out))
      else $error("direction changed alone");
endmodule // tcc_port_sva

bind tcc_port tcc_port_sva tcc_port_sva_i (.*);

/* File: bench/tcc_tape_model.sv */
// Purpose: Behavioural tape unit facing the channel port
// Assumes: Strobe idles high between characters
// Notes:   Released character lines show the inverse of their last value
`timescale 1ns/10ps
module tcc_tape_model (
   // From channel
   input  wire logic [5:0] char_in,
   input  wire logic       pend_in,
   input  wire logic       clkp_in,
   // To channel
   output logic [5:0]      char_n_out,
   output logic            par_n_out,
   output logic            strobe_out,
   output logic            halt_n_out,
   output logic            skip_n_out,
   output logic            gap_n_out,
   output logic            err_n_out
);
   initial
   begin
      char_n_out = 6'h3F;
      par_n_out = 1'b1;
      strobe_out = 1'b1;
      {halt_n_out, skip_n_out, gap_n_out, err_n_out} = 4'hF;
   end
   task automatic xfer(input logic [5:0] c, output logic [5:0] got, input logic bad = 1'b0);
      wait (!pend_in && !clkp_in);
      #3 char_n_out = ~c;
      par_n_out = ^c ^ bad;
      #80 strobe_out = 1'b0;
      #80 strobe_out = 1'b1;
      got = char_in;
      #80 char_n_out = c;
      par_n_out = ~^c;
   endtask
   // Off the clock edge so the sync flops never see a tie
   task automatic lines(input logic [3:0] v);
      #3 {halt_n_out, skip_n_out, gap_n_out, err_n_out} = v;
   endtask
endmodule // tcc_tape_model

/* File: bench/test_tcc_port.sv */
// Purpose: Self-checking bench for the tape character channel port
// Assumes: Tape model keeps the strobe interlock
// Notes:   Scenarios run in turn, then conclude
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module test_tcc_port;
   import tcc_pkg::*;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
   logic [3:0]  s_axi_wstrb_in;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp;
   logic        clock_in, sys_rst_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
   logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
   logic        s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
   logic [5:0]  char_in_n_in, char_out, got;
   logic [4:0]  unit_addr_out;
   logic        char_par_n_in, xfer_strobe_in, halt_n_in, skip_resp_n_in, gap_n_in, error_n_in;
   logic        char_par_out, buf_ctl_strobe_out, io_ctl_strobe_out, halt_interlock_out;
   logic        xfer_pending_out, clock_present_out, phase_window_t6_t3_out, direction_bit_out;
   int          n_mismatch, comparisons, n_buc, n_ioc;
   tcc_port tcc_port_i (.*);
   tcc_tape_model tcc_tape_model_i (.char_in(char_out), .pend_in(xfer_pending_out),
      .clkp_in(clock_present_out), .char_n_out(char_in_n_in), .par_n_out(char_par_n_in),
      .strobe_out(xfer_strobe_in), .halt_n_out(halt_n_in), .skip_n_out(skip_resp_n_in),
      .gap_n_out(gap_n_in), .err_n_out(error_n_in));
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(posedge clock_in)
   begin
      if (buf_ctl_strobe_out === 1'b1) n_buc++;
      if (io_ctl_strobe_out === 1'b1) n_ioc++;
   end
   task automatic clks(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      {s_axi_awaddr_in, s_axi_wdata_in} <= {a, d};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
      do
      begin
         @(posedge clock_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      r = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr_in <= a;
      {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
      do
      begin
         @(posedge clock_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      {d, r} = {s_axi_rdata_out, s_axi_rresp_out};
      s_axi_rready_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic t_regs;
      `CHK(char_par_out, 1'b1)
      axw(OFS_CTRL, 32'h56, rsp);
      `CHK({rsp, direction_bit_out}, {RESP_OKAY, 1'b1})
      `CHK(unit_addr_out, 5'h15)
      axr(OFS_CTRL, rd, rsp);
      `CHK({rsp, rd[6:1]}, {RESP_OKAY, 6'h2B})
      axw(8'h10, 32'h0, rsp);
      `CHK(rsp, RESP_SLVERR)
      axr(OFS_INSTR, rd, rsp);
      `CHK(rsp, RESP_SLVERR)
      $display("test regs done");
   endtask
   task automatic t_input;
      logic [5:0] c[4] = '{6'h21, 6'h3F, 6'h00, 6'h1A};
      axw(OFS_CTRL, 32'h1, rsp);
      for (int k = 0; k < 4; k++)
      begin
         tcc_tape_model_i.xfer(c[k], got, k == 1);
         clks(1);
         `CHK(char_out, c[k])
      end
      clks(40);
      `CHK(halt_interlock_out, 1'b1)
      axr(OFS_STAT, rd, rsp);
      `CHK(rd[ST_PERR:ST_WRDY], 2'b11)
      axr(OFS_DATA, rd, rsp);
      `CHK(rd[23:0], {c[0], c[1], c[2], c[3]})
      $display("test input done");
   endtask
   task automatic t_halt;
      axw(OFS_CTRL, 32'h1, rsp);
      tcc_tape_model_i.xfer(6'h07, got);
      tcc_tape_model_i.lines(4'h7);
      clks(8);
      `CHK(xfer_pending_out, 1'b0)
      axr(OFS_STAT, rd, rsp);
      `CHK({rd[ST_HALTED], rd[ST_ACTIVE]}, 2'b10)
      tcc_tape_model_i.lines(4'hF);
      clks(1);
      $display("test halt done");
   endtask
   task automatic t_output;
      logic [23:0] w = 24'h5A3C96;
      axw(OFS_CTRL, 32'h3, rsp);
      axw(OFS_DATA, {8'h00, w}, rsp);
      for (int k = 0; k < 4; k++)
      begin
         tcc_tape_model_i.xfer(6'h00, got);
         `CHK(got, w[23-6*k -: 6])
      end
      clks(40);
      axr(OFS_STAT, rd, rsp);
      `CHK({halt_interlock_out, rd[ST_WRDY]}, 2'b11)
      $display("test output done");
   endtask
   task automatic t_lines;
      axw(OFS_INSTR, 32'h1, rsp);
      axw(OFS_INSTR, 32'h3, rsp);
      `CHK(n_buc, 1)
      `CHK(n_ioc, 1)
      for (int k = 0; k < 2; k++)
      begin
         tcc_tape_model_i.lines(k ? 4'hF : 4'hB);
         clks(6);
         axw(OFS_INSTR, 32'h4, rsp);
         axr(OFS_STAT, rd, rsp);
         `CHK(rd[ST_SKIP], k ? 1'b0 : 1'b1)
      end
      tcc_tape_model_i.lines(4'hC);
      clks(6);
      axr(OFS_STAT, rd, rsp);
      `CHK(rd[ST_GAP:ST_ERR], 2'b11)
      tcc_tape_model_i.lines(4'hF);
      clks(6);
      axw(OFS_STAT, 32'h1E0, rsp);
      axr(OFS_STAT, rd, rsp);
      `CHK(rd[ST_HALTED:ST_PERR], 4'h0)
      $display("test lines done");
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      {sys_rst_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = {1'b1, 48'h0};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
      {s_axi_arvalid_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h0F;
      {n_mismatch, comparisons, n_buc, n_ioc} = '0;
      clks(3);
      sys_rst_in <= 1'b0;
      clks(1);
      t_regs;
      t_input;
      t_halt;
      t_output;
      t_lines;
      conclude;
   end
   // Whole run needs well under a thousand clocks
   initial
   begin
      #200000;
      n_mismatch++;
      conclude;
   end
endmodule // test_tcc_port
